// ---- logic/fcl_defs.svh ----
// offsets, field positions, reset values and timing counts of the fuse loader
`ifndef FCL_DEFS_SVH
`define FCL_DEFS_SVH
`define FCL_OFF_WATCHDOG 4'h0
`define FCL_OFF_BROWNOUT 4'h1
`define FCL_OFF_OSCILLATOR 4'h2
`define FCL_OFF_SYSTEM_ZERO 4'h5
`define FCL_OFF_STARTUP 4'h6
`define FCL_OFF_APP_END 4'h7
`define FCL_OFF_BOOT_END 4'h8
`define FCL_FUSE_COUNT 4'h9
`define FCL_WDT_WINDOW_HI 7
`define FCL_WDT_WINDOW_LO 4
`define FCL_WDT_PERIOD_HI 3
`define FCL_WDT_PERIOD_LO 0
`define FCL_BOD_LEVEL_HI 7
`define FCL_BOD_LEVEL_LO 5
`define FCL_BOD_SAMP_BIT 4
`define FCL_BOD_ACT_HI 3
`define FCL_BOD_ACT_LO 2
`define FCL_BOD_SLP_HI 1
`define FCL_BOD_SLP_LO 0
`define FCL_OSC_LOCK_BIT 7
`define FCL_OSC_FSEL_HI 1
`define FCL_OSC_FSEL_LO 0
`define FCL_SYS_CRC_HI 7
`define FCL_SYS_CRC_LO 6
`define FCL_SYS_TOUT_BIT 4
`define FCL_SYS_RPIN_HI 3
`define FCL_SYS_RPIN_LO 2
`define FCL_SYS_KEEP_EE_BIT 0
`define FCL_DLY_SEL_HI 2
`define FCL_DLY_SEL_LO 0
`define FCL_FUSE_RESET 8'hFF
`define FCL_BLOCK_SLOW_CYCLES 768
`define FCL_SLOW_CNT_W 10
`define FCL_CLK_HZ 40000000
`define FCL_DLY_MS_MAX 64
`endif

// ---- logic/fcl_pkg.sv ----
// types shared by the fuse configuration loader
package fcl_pkg;
	typedef enum logic [1:0] {FCL_RPIN_GPIO, FCL_RPIN_DEBUG, FCL_RPIN_RESET,
		FCL_RPIN_DEBUG_ALT} fcl_rpin_t;
	typedef enum logic [1:0] {FCL_CRC_FULL, FCL_CRC_BOOT, FCL_CRC_BOOTAPP,
		FCL_CRC_NONE} fcl_crc_t;
	typedef enum logic [1:0] {FCL_FSEL_RES0, FCL_FSEL_16M, FCL_FSEL_20M,
		FCL_FSEL_RES3} fcl_fsel_t;
endpackage : fcl_pkg

// ---- logic/fcl_slow_timer.sv ----
// counts slow-oscillator edges up to a limit and reports when done
`timescale 1ns/100ps
module fcl_slow_timer #(
	parameter int CNT_W = 10,
	parameter logic [CNT_W-1:0] LIMIT = 10'd768
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic start,
	input wire logic slow_edge,
	output logic done
);
	logic [CNT_W-1:0] cnt_q;

	// restart on start, then count each slow edge until the limit
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			cnt_q <= '0;
		else if (start)
			cnt_q <= '0;
		else if (slow_edge && cnt_q != LIMIT)
			cnt_q <= cnt_q + 1'b1;
	end

	assign done = (cnt_q == LIMIT);
endmodule : fcl_slow_timer

// ---- logic/fcl_loader.sv ----
// fuse configuration loader: reads fuses at reset and drives targets
`timescale 1ns/100ps
`include "fcl_defs.svh"

// Functional notes
// - watchdog window fuse bits 7:4 go to the watchdog window field
// - watchdog period fuse bits 3:0 go to the watchdog period field
// - brown-out level bits 7:5 go to brown-out control B level
// - sample-rate bit goes to brown-out control A; 0 is 1 kHz
// - active brown-out mode bits 3:2 go to brown-out control A
// - sleep brown-out mode bits 1:0 go to brown-out control A
// - oscillator lock fuse bit goes to calibration B lock bit
// - frequency select picks 16 or 20 MHz and matching trims
// - checksum scope bits 7:6 select start-up checksum coverage
// - unless disabled, block nonvolatile writes 768 slow cycles after power-on; the code blocks only with the pin as gpio or reset
// - reset pin function bits 3:2 set the pin role
// - reset pin as GPIO keeps driver off 768 slow cycles after reset
// - keep-on-erase bit set means chip erase clears only flash
// - a locked device always clears eeprom on chip erase
// - start-up delay bits 2:0 select 0 to 64 ms
// - application end byte sizes boot plus application in 256-byte blocks
// - boot end byte sizes boot section in 256-byte blocks
// - boot end zero makes the whole flash boot section
// - fuse values reach targets only in the apply cycle, before the start-up wait, except keep-on-erase and write-block disable, read from the shadow copy
module fcl_loader #(
	parameter int CLK_HZ = `FCL_CLK_HZ,
	parameter int DELAY_MS_MAX = `FCL_DLY_MS_MAX,
	parameter int MS_CYCLES = CLK_HZ / 1000
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic por_pulse,
	input wire logic slow_osc_in,
	output logic [3:0] fuse_addr,
	output logic fuse_rd,
	input wire logic [7:0] fuse_rdata,
	input wire logic [7:0] osc_frequency_trim_16m,
	input wire logic [7:0] osc_frequency_trim_20m,
	input wire logic [7:0] osc_temperature_trim_16m,
	input wire logic [7:0] osc_temperature_trim_20m,
	input wire logic device_locked,
	input wire logic chip_erase_req,
	output logic internal_reset,
	output logic [3:0] wdt_window,
	output logic [3:0] wdt_period,
	output logic [2:0] brownout_threshold,
	output logic brownout_sample_rate,
	output logic [1:0] brownout_active_mode,
	output logic [1:0] brownout_sleep_mode,
	output logic osc_calibration_lock,
	output logic [7:0] osc_frequency_trim,
	output logic [7:0] osc_temperature_trim,
	output logic osc_run_16m,
	output fcl_pkg::fcl_crc_t startup_checksum_scope,
	output fcl_pkg::fcl_rpin_t reset_pin_function,
	output logic nvm_write_blocked,
	output logic rpin_driver_off,
	output logic erase_eeprom,
	output logic erase_flash,
	output logic [7:0] app_section_end,
	output logic [7:0] boot_section_end,
	output logic whole_flash_boot,
	output logic [7:0] fuse_rd_data,
	input wire logic [3:0] fuse_rd_addr
);
	import fcl_pkg::*;

	// two cycles per fuse byte, then one apply cycle and the start-up wait
	typedef enum logic [2:0] {FCL_ST_READ, FCL_ST_CAPTURE, FCL_ST_APPLY,
		FCL_ST_DELAY, FCL_ST_RUN} fcl_state_t;

	// delay counter sized for the longest start-up code
	localparam int DLY_MAX_CYCLES = DELAY_MS_MAX * MS_CYCLES;
	localparam int DLY_W = $clog2(DLY_MAX_CYCLES + 1);

	fcl_state_t state_q;
	logic [3:0] addr_q;
	// offsets 3 and 4 hold no fuse; their slots keep the reset value
	logic [7:0] shadow_q [0:8];
	logic [DLY_W-1:0] dly_q;
	logic slow_s1_q, slow_s2_q, slow_s3_q, slow_prev_q;
	logic slow_edge;
	logic timer_start;
	logic timer_done;
	logic por_seen_q;
	logic blocking_en;
	logic [DLY_W-1:0] dly_limit;
	logic [2:0] dly_code;

	// slow oscillator crosses in through three stages; edge from stages 2/3
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			slow_s1_q <= 1'b0;
			slow_s2_q <= 1'b0;
			slow_s3_q <= 1'b0;
			slow_prev_q <= 1'b0;
		end
		else
		begin
			slow_s1_q <= slow_osc_in;
			slow_s2_q <= slow_s1_q;
			slow_s3_q <= slow_s2_q;
			if (slow_s2_q == slow_s3_q)
				slow_prev_q <= slow_s3_q;
		end
	end

	// counts a rising edge only once stages 2 and 3 agree
	assign slow_edge = (slow_s2_q == slow_s3_q) && slow_s3_q && !slow_prev_q;

	// fuses are read one at a time; internal reset holds through it all
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= FCL_ST_READ;
			addr_q <= 4'h0;
			dly_q <= '0;
		end
		else
		begin
			case (state_q)
				FCL_ST_READ:
					state_q <= FCL_ST_CAPTURE;
				FCL_ST_CAPTURE:
				begin
					if (addr_q == `FCL_FUSE_COUNT - 4'h1)
						state_q <= FCL_ST_APPLY;
					else
					begin
						addr_q <= addr_q + 4'h1;
						state_q <= FCL_ST_READ;
					end
				end
				FCL_ST_APPLY:
				begin
					dly_q <= '0;
					state_q <= FCL_ST_DELAY;
				end
				FCL_ST_DELAY:
				begin
					if (dly_q >= dly_limit)
						state_q <= FCL_ST_RUN;
					else
						dly_q <= dly_q + 1'b1;
				end
				FCL_ST_RUN:
					state_q <= FCL_ST_RUN;
				default:
					state_q <= FCL_ST_READ;
			endcase
		end
	end

	assign fuse_addr = addr_q;
	assign fuse_rd = (state_q == FCL_ST_READ);

	// shadow copy of each fuse byte, reserved bits read as one until loaded
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 9; i++)
				shadow_q[i] <= `FCL_FUSE_RESET;
		end
		else if (state_q == FCL_ST_CAPTURE && addr_q != 4'h3 && addr_q != 4'h4)
			shadow_q[addr_q] <= fuse_rdata;
	end

	// start-up delay in clock cycles per code: 0,1,2,4..64 ms
	// code n waits one millisecond doubled n-1 times; code 0 skips the wait
	assign dly_code =
		shadow_q[`FCL_OFF_STARTUP][`FCL_DLY_SEL_HI:`FCL_DLY_SEL_LO];
	always_comb
	begin
		if (dly_code == 3'h0)
			dly_limit = '0;
		else
			dly_limit = DLY_W'(MS_CYCLES << (dly_code - 3'h1));
	end

	// targets load once in the apply cycle, before the start-up wait, so later fuse edits need reset
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wdt_window <= 4'h0;
			wdt_period <= 4'h0;
			brownout_threshold <= 3'h0;
			brownout_sample_rate <= 1'b0;
			brownout_active_mode <= 2'h0;
			brownout_sleep_mode <= 2'h0;
			osc_calibration_lock <= 1'b0;
			osc_frequency_trim <= 8'h00;
			osc_temperature_trim <= 8'h00;
			osc_run_16m <= 1'b0;
			startup_checksum_scope <= FCL_CRC_NONE;
			reset_pin_function <= FCL_RPIN_RESET;
			app_section_end <= 8'h00;
			boot_section_end <= 8'h00;
		end
		else if (state_q == FCL_ST_APPLY)
		begin
			wdt_window <= shadow_q[`FCL_OFF_WATCHDOG]
				[`FCL_WDT_WINDOW_HI:`FCL_WDT_WINDOW_LO];
			wdt_period <= shadow_q[`FCL_OFF_WATCHDOG]
				[`FCL_WDT_PERIOD_HI:`FCL_WDT_PERIOD_LO];
			brownout_threshold <= shadow_q[`FCL_OFF_BROWNOUT]
				[`FCL_BOD_LEVEL_HI:`FCL_BOD_LEVEL_LO];
			brownout_sample_rate <=
				shadow_q[`FCL_OFF_BROWNOUT][`FCL_BOD_SAMP_BIT];
			brownout_active_mode <= shadow_q[`FCL_OFF_BROWNOUT]
				[`FCL_BOD_ACT_HI:`FCL_BOD_ACT_LO];
			brownout_sleep_mode <= shadow_q[`FCL_OFF_BROWNOUT]
				[`FCL_BOD_SLP_HI:`FCL_BOD_SLP_LO];
			osc_calibration_lock <=
				shadow_q[`FCL_OFF_OSCILLATOR][`FCL_OSC_LOCK_BIT];
			// reserved frequency codes fall back to the 20 MHz trims
			if (fcl_fsel_t'(shadow_q[`FCL_OFF_OSCILLATOR]
				[`FCL_OSC_FSEL_HI:`FCL_OSC_FSEL_LO]) == FCL_FSEL_16M)
			begin
				osc_run_16m <= 1'b1;
				osc_frequency_trim <= osc_frequency_trim_16m;
				osc_temperature_trim <= osc_temperature_trim_16m;
			end
			else
			begin
				osc_run_16m <= 1'b0;
				osc_frequency_trim <= osc_frequency_trim_20m;
				osc_temperature_trim <= osc_temperature_trim_20m;
			end
			startup_checksum_scope <= fcl_crc_t'(shadow_q[`FCL_OFF_SYSTEM_ZERO]
				[`FCL_SYS_CRC_HI:`FCL_SYS_CRC_LO]);
			reset_pin_function <= fcl_rpin_t'(shadow_q[`FCL_OFF_SYSTEM_ZERO]
				[`FCL_SYS_RPIN_HI:`FCL_SYS_RPIN_LO]);
			app_section_end <= shadow_q[`FCL_OFF_APP_END];
			boot_section_end <= shadow_q[`FCL_OFF_BOOT_END];
		end
	end

	// the rest of the chip stays in reset until the start-up wait ends
	assign internal_reset = (state_q != FCL_ST_RUN);
	assign whole_flash_boot = (boot_section_end == 8'h00);

	// remember whether this start-up followed a power-on
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			por_seen_q <= 1'b0;
		else if (por_pulse)
			por_seen_q <= 1'b1;
		else if (state_q == FCL_ST_RUN && timer_done)
			por_seen_q <= 1'b0;
	end

	// both windows start in the apply cycle, before the start-up wait and the hand-over to the running device
	assign timer_start = (state_q == FCL_ST_APPLY);

	// one shared timer: both windows have the same length and start point
	fcl_slow_timer #(
		.CNT_W(`FCL_SLOW_CNT_W),
		.LIMIT(`FCL_SLOW_CNT_W'(`FCL_BLOCK_SLOW_CYCLES))
	) u_slow_timer (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.start(timer_start),
		.slow_edge(slow_edge),
		.done(timer_done)
	);

	// write block applies only after power-on, with pin as gpio or reset
	assign blocking_en = !shadow_q[`FCL_OFF_SYSTEM_ZERO][`FCL_SYS_TOUT_BIT] &&
		(reset_pin_function == FCL_RPIN_GPIO ||
		reset_pin_function == FCL_RPIN_RESET);
	assign nvm_write_blocked = internal_reset ||
		(blocking_en && por_seen_q && !timer_done);

	// gpio driver stays off to avoid fighting a high-voltage debug entry
	assign rpin_driver_off = internal_reset ||
		(reset_pin_function == FCL_RPIN_GPIO && !timer_done);

	// chip erase: flash always; eeprom unless kept and device open
	assign erase_flash = chip_erase_req;
	assign erase_eeprom = chip_erase_req && (device_locked ||
		!shadow_q[`FCL_OFF_SYSTEM_ZERO][`FCL_SYS_KEEP_EE_BIT]);

	// read port for software; gap and unmapped offsets read as zero
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			fuse_rd_data <= 8'h00;
		else if (fuse_rd_addr < `FCL_FUSE_COUNT && fuse_rd_addr != 4'h3 &&
			fuse_rd_addr != 4'h4)
			fuse_rd_data <= shadow_q[fuse_rd_addr];
		else
			fuse_rd_data <= 8'h00;
	end
endmodule : fcl_loader

// ---- tb/fcl_fuse_model.sv ----
// behavioural fuse array answering the loader's byte reads
`timescale 1ns/100ps
module fcl_fuse_model (
	input wire logic clk_sys,
	input wire logic [3:0] fuse_addr,
	input wire logic fuse_rd,
	input wire logic [71:0] img,
	output logic [7:0] fuse_rdata
);
	// byte shows one cycle after the read; idle data flips so stale
	// values never look valid
	always_ff @(posedge clk_sys)
	begin
		if (fuse_rd)
			fuse_rdata <= img[fuse_addr*8 +: 8];
		else
			fuse_rdata <= ~fuse_rdata;
	end
endmodule : fcl_fuse_model

// ---- tb/fcl_loader_props.sv ----
// concurrent checks on the fuse loader's ports
`timescale 1ns/100ps
module fcl_loader_props (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [3:0] fuse_addr,
	input wire logic fuse_rd,
	input wire logic device_locked,
	input wire logic chip_erase_req,
	input wire logic internal_reset,
	input wire logic [3:0] wdt_window,
	input wire logic [7:0] boot_section_end,
	input wire fcl_pkg::fcl_rpin_t reset_pin_function,
	input wire logic nvm_write_blocked,
	input wire logic rpin_driver_off,
	input wire logic erase_eeprom,
	input wire logic erase_flash,
	input wire logic whole_flash_boot
);
	import fcl_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	a_read_order_step:
		assert property (fuse_rd && fuse_addr < 4'h8 |=> !fuse_rd ##1
			(fuse_rd && fuse_addr == $past(fuse_addr, 2) + 4'h1))
		else $error("fuse reads out of order");
	a_load_under_reset:
		assert property (fuse_rd |-> internal_reset)
		else $error("fuse read while running");
	a_targets_frozen:
		assert property (!internal_reset |=> $stable(wdt_window) &&
			$stable(boot_section_end))
		else $error("target changed while running");
	a_boot_zero_whole:
		assert property (whole_flash_boot == (boot_section_end == 8'h00))
		else $error("whole flash flag wrong");
	a_flash_erase_follow:
		assert property (erase_flash == chip_erase_req)
		else $error("flash erase not following request");
	a_no_request_erase:
		assert property (!chip_erase_req |-> !erase_eeprom)
		else $error("eeprom erase without request");
	a_locked_clears_eeprom:
		assert property (chip_erase_req && device_locked |-> erase_eeprom)
		else $error("locked erase kept eeprom");
	a_debug_pin_free:
		assert property (!internal_reset && reset_pin_function inside
			{FCL_RPIN_DEBUG, FCL_RPIN_DEBUG_ALT} |->
			!nvm_write_blocked && !rpin_driver_off)
		else $error("block active with debug pin");
	a_gpio_driver_held:
		assert property ($fell(internal_reset) &&
			reset_pin_function == FCL_RPIN_GPIO |-> rpin_driver_off)
		else $error("gpio driver enabled too early");
	cover property (chip_erase_req && device_locked);
	cover property ($fell(internal_reset));
	cover property ($fell(rpin_driver_off));
endmodule : fcl_loader_props

bind fcl_loader fcl_loader_props chk_u (.clk_sys, .arst_n, .fuse_addr,
	.fuse_rd, .device_locked, .chip_erase_req, .internal_reset,
	.wdt_window, .boot_section_end, .reset_pin_function,
	.nvm_write_blocked, .rpin_driver_off, .erase_eeprom, .erase_flash,
	.whole_flash_boot);

// ---- tb/tb_top.sv ----
// self-checking bench for the fuse configuration loader
`timescale 1ns/100ps
module tb_top;
	import fcl_pkg::*;
	logic clk_sys = 1'b0, arst_n = 1'b0, por_pulse = 1'b1;
	logic device_locked = 1'b0, chip_erase_req = 1'b0;
	logic [2:0] slow_div = 3'h0;
	logic [3:0] fuse_rd_addr = 4'h0;
	logic [71:0] img = '1;
	logic [7:0] osc_frequency_trim_16m = 8'h16;
	logic [7:0] osc_frequency_trim_20m = 8'h20;
	logic [7:0] osc_temperature_trim_16m = 8'hA6;
	logic [7:0] osc_temperature_trim_20m = 8'hA2;
	logic [3:0] fuse_addr, wdt_window, wdt_period;
	logic fuse_rd, internal_reset, brownout_sample_rate, osc_run_16m;
	logic osc_calibration_lock, nvm_write_blocked, rpin_driver_off;
	logic erase_eeprom, erase_flash, whole_flash_boot, slow_osc_in;
	logic [2:0] brownout_threshold;
	logic [1:0] brownout_active_mode, brownout_sleep_mode;
	logic [7:0] fuse_rdata, osc_frequency_trim, osc_temperature_trim;
	logic [7:0] app_section_end, boot_section_end, fuse_rd_data;
	fcl_crc_t startup_checksum_scope;
	fcl_rpin_t reset_pin_function;
	int n_mismatch = 0, cmp_count = 0, cycles = 0, base = 0;
	// reserved bits all ones; order wdt,bod,osc,3,4,sys0,sut,app,boot
	logic [71:0] imgs [4] = '{72'h10_20_F8_F6_FFFF_7E_1E_5A,
		72'h00_40_FA_23_FFFF_FD_E9_A5, 72'hFF_FF_FF_AA_FFFF_7F_C4_3C,
		72'h01_02_F9_6E_FFFF_7C_33_0F};

	fcl_loader #(.MS_CYCLES(4)) dut_u (.clk_sys, .arst_n, .por_pulse,
		.slow_osc_in, .fuse_addr, .fuse_rd, .fuse_rdata,
		.osc_frequency_trim_16m, .osc_frequency_trim_20m,
		.osc_temperature_trim_16m, .osc_temperature_trim_20m,
		.device_locked, .chip_erase_req, .internal_reset, .wdt_window,
		.wdt_period, .brownout_threshold, .brownout_sample_rate,
		.brownout_active_mode, .brownout_sleep_mode,
		.osc_calibration_lock, .osc_frequency_trim, .osc_temperature_trim,
		.osc_run_16m, .startup_checksum_scope, .reset_pin_function,
		.nvm_write_blocked, .rpin_driver_off, .erase_eeprom, .erase_flash,
		.app_section_end, .boot_section_end, .whole_flash_boot,
		.fuse_rd_data, .fuse_rd_addr);
	fcl_fuse_model far_u (.clk_sys, .fuse_addr, .fuse_rd, .img,
		.fuse_rdata);

	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end

	// slow oscillator runs free at an eighth of the system clock
	always @(negedge clk_sys) slow_div <= slow_div + 3'h1;
	assign slow_osc_in = slow_div[2];

	// hang guard: longest boot plus the 768-edge window, four times over
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	initial
	begin
		logic [7:0] w, b, o, s, u, dl;
		int n;
		for (int i = 0; i < 4; i++)
		begin
			{b, u, s} = {imgs[i][71:64], imgs[i][55:48], imgs[i][47:40]};
			{o, dl, w} = {imgs[i][23:16], imgs[i][15:8], imgs[i][7:0]};
			img = imgs[i];
			arst_n = 1'b0;
			// third start-up is a warm reset: no power-on, so no write block
			por_pulse = (i != 2);
			repeat (6) @(negedge clk_sys);
			arst_n = 1'b1;
			// power-on marker outlasts reset so the loader can latch it
			@(negedge clk_sys);
			por_pulse = 1'b0;
			n = 1;
			while (internal_reset !== 1'b0)
			begin
				@(negedge clk_sys);
				n++;
			end
			// first image has delay code 0 and gives the base time
			if (i == 0)
				base = n;
			chk("delay", n - base >= (u[2:0] ? 4 << (u[2:0] - 1) : 0) &&
				n - base <= (u[2:0] ? 4 << (u[2:0] - 1) : 0) + 1, 1);
			chk("window", wdt_window, w[7:4]);
			chk("period", wdt_period, w[3:0]);
			chk("level", brownout_threshold, dl[7:5]);
			chk("rate", brownout_sample_rate, dl[4]);
			chk("active", brownout_active_mode, dl[3:2]);
			chk("sleep", brownout_sleep_mode, dl[1:0]);
			chk("lock", osc_calibration_lock, o[7]);
			chk("run16", osc_run_16m, o[1:0] == 2'h1);
			chk("ftrim", osc_frequency_trim, o[1:0] == 2'h1 ?
				8'h16 : 8'h20);
			chk("ttrim", osc_temperature_trim, o[1:0] == 2'h1 ?
				8'hA6 : 8'hA2);
			chk("scope", startup_checksum_scope, s[7:6]);
			chk("pin", reset_pin_function, s[3:2]);
			chk("app", app_section_end, imgs[i][63:56]);
			chk("boot", boot_section_end, b);
			chk("whole", whole_flash_boot, b == 8'h00);
			chk("nvm", nvm_write_blocked, !s[4] && !s[2] && i != 2);
			chk("drv", rpin_driver_off, s[3:2] == 2'h0);
			chip_erase_req = 1'b1; // no memory busy in this model
			fuse_rd_addr = 4'h5;
			@(negedge clk_sys);
			chk("flash", erase_flash, 1);
			chk("eeprom", erase_eeprom, !s[0]);
			chk("fuse", fuse_rd_data, s);
			device_locked = 1'b1;
			fuse_rd_addr = 4'h3;
			@(negedge clk_sys);
			chk("locked", erase_eeprom, 1);
			chk("resv", fuse_rd_data, 0);
			{chip_erase_req, device_locked} = 2'b00;
			img = ~imgs[i];
			repeat (6300) @(negedge clk_sys);
			chk("nvm_end", nvm_write_blocked, 0);
			chk("drv_end", rpin_driver_off, 0);
			chk("kept", wdt_window, w[7:4]);
		end
		end_sim();
	end
endmodule : tb_top
